// >>> common/sra_pkg.sv
package sra_pkg;
   // ************************************************************
   // frame layout
   // ************************************************************
   localparam int CMD_BITS = 16;
   localparam int ADDR_BITS = 7;
   localparam int MODE_POS = 7;
   localparam int DATA_LSB = 8;
   localparam logic [4:0] CNT_ADDR_DONE = 5'h07;
   localparam logic [4:0] CNT_FULL = 5'h10;
   localparam logic [4:0] CNT_OVER = 5'h11;
   // ************************************************************
   // register addresses
   // ************************************************************
   localparam logic [6:0] ADR_OPT_TRIM_H = 7'h35;
   localparam logic [6:0] ADR_OSC_CAL_H = 7'h36;
   localparam logic [6:0] ADR_CDR_LIM_H = 7'h3C;
   localparam logic [6:0] ADR_CDR_LIM_L = 7'h3D;
   localparam logic [6:0] ADR_SUPPLY_STATUS_SECOND = 7'h40;
   localparam logic [6:0] ADR_SUPPLY_STATUS_FIRST = 7'h41;
   localparam logic [6:0] ADR_THERMAL_STATUS = 7'h42;
   localparam logic [6:0] ADR_DEV_COND = 7'h43;
   localparam logic [6:0] ADR_SELECTIVE_WAKE_STATUS = 7'h70;
   localparam logic [6:0] ADR_ECNT_STAT = 7'h71;
   // ************************************************************
   // implemented-bit masks, reserved bits are zero here
   // ************************************************************
   localparam logic [7:0] MSK_OPT_TRIM_H = 8'h9F;
   localparam logic [7:0] MSK_FULL = 8'hFF;
   localparam logic [7:0] MSK_SUPPLY_STATUS_SECOND = 8'h5F;
   localparam logic [7:0] MSK_THERM = 8'h07;
   localparam logic [7:0] MSK_DEV_COND = 8'hCF;
   localparam logic [7:0] MSK_SELECTIVE_WAKE_STATUS = 8'h4F;
   localparam logic [7:0] MSK_ECNT = 8'h3F;
   // ************************************************************
   // reset and restart values, keep mask marks don't-change bits
   // ************************************************************
   localparam logic [7:0] POR_CTRL = 8'h00;
   localparam logic [7:0] POR_STAT = 8'h00;
   localparam logic [7:0] POR_SUPPLY_STATUS_FIRST = 8'h80;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] KEEP_CTRL = 8'hFF;
   localparam logic [7:0] RST_STAT = 8'h00;
   localparam logic [7:0] KEEP_STAT = 8'hFF;
   localparam logic [7:0] KEEP_NONE = 8'h00;
   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic sclk;
      logic csn;
      logic mosi;
   } sra_pins_t;
   typedef struct packed {
      logic [7:0] sup2;
      logic [7:0] sup1;
      logic [7:0] therm;
      logic [7:0] dev;
   } sra_evt_t;
   typedef struct packed {
      logic [7:0] osc_cal_h;
      logic [7:0] swk;
      logic [7:0] ecnt;
   } sra_ro_t;
   typedef struct packed {
      logic [7:0] opt_trim_h;
      logic [7:0] cdr_lim_h;
      logic [7:0] cdr_lim_l;
   } sra_ctrl_t;
   typedef enum logic [1:0] {
      SRA_IDLE = 2'b00,
      SRA_SHIFT = 2'b01
   } sra_fsm_t;
   typedef struct packed {
      sra_fsm_t fsm;
      logic [2:0] sclk_s;
      logic [2:0] csn_s;
      logic [1:0] mosi_s;
      logic [4:0] cnt;
      logic [15:0] rx;
      logic [7:0] tx;
      logic miso;
      logic wr_pulse;
      logic wr_mode;
      logic [6:0] wr_addr;
      logic [7:0] wr_data;
   } sra_st_t;
endpackage

// >>> core/sra_reg_cell.sv
`timescale 1ns/1ps
`default_nettype none
module sra_reg_cell
   import sra_pkg::*;
#(
   parameter logic [7:0] POR_VAL = 8'h00,
   parameter logic [7:0] RST_VAL = 8'h00,
   parameter logic [7:0] KEEP_MSK = 8'h00,
   parameter logic [7:0] BIT_MSK = 8'hFF,
   parameter bit CLR_ON_WR = 1'b0
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic soft_rst,
   input wire logic restart,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] hw_set,
   output logic [7:0] q
);
   logic [7:0] q_r;
   logic [7:0] q_nxt;
   // priority: soft reset, restart, write; hardware set always lands last
   always_comb begin
      q_nxt = q_r;
      if (soft_rst) begin
         q_nxt = POR_VAL;
      end else if (restart) begin
         q_nxt = (q_r & KEEP_MSK) | (RST_VAL & ~KEEP_MSK);
      end else if (wr_en) begin
         // status flags clear on write, control bits take the byte
         q_nxt = CLR_ON_WR ? 8'h00 : wr_data;
      end
      // set beats clear so no event is lost in the clearing cycle
      q_nxt = (q_nxt | hw_set) & BIT_MSK;
   end
   // register the byte, no other source can move it
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         q_r <= POR_VAL & BIT_MSK;
      end else begin
         q_r <= q_nxt;
      end
   end
   assign q = q_r;
   a_set_wins: assert property (@(posedge core_clk) disable iff (!reset_n)
      (|(hw_set & BIT_MSK)) |=> ((q_r & $past(hw_set) & BIT_MSK) == ($past(hw_set) & BIT_MSK)))
      else $error("hardware set lost");
   a_restart_keep: assert property (@(posedge core_clk) disable iff (!reset_n)
      (restart && !soft_rst && hw_set == 8'h00) |=>
      (q_r == (($past(q_r) & KEEP_MSK) | (RST_VAL & ~KEEP_MSK & BIT_MSK))))
      else $error("restart value wrong");
   a_hold_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
      (!soft_rst && !restart && !wr_en && hw_set == 8'h00) |=> $stable(q_r))
      else $error("register changed on its own");
endmodule // sra_reg_cell
`default_nettype wire

// >>> core/sra_spi_bank.sv
`timescale 1ns/1ps
`default_nettype none
module sra_spi_bank
   import sra_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire sra_pins_t pins,
   output logic miso_o,
   output logic miso_oe_n,
   input wire logic soft_rst,
   input wire logic restart,
   input wire sra_evt_t evt,
   input wire sra_ro_t ro_in,
   output sra_ctrl_t ctrl
);
   // ************************************************************
   // state and decode helpers
   // ************************************************************
   sra_st_t st_r;
   sra_st_t st_nxt;
   logic sclk_rise;
   logic sclk_fall;
   logic csn_rise;
   logic csn_fall;
   logic [7:0] q_sup2;
   logic [7:0] q_sup1;
   logic [7:0] q_therm;
   logic [7:0] q_dev;
   logic [7:0] q_opt;
   logic [7:0] q_cdrh;
   logic [7:0] q_cdrl;
   logic [7:0] echo_now;

   // edges from the second and third sync stages only
   assign sclk_rise = st_r.sclk_s[1] & ~st_r.sclk_s[2];
   assign sclk_fall = ~st_r.sclk_s[1] & st_r.sclk_s[2];
   assign csn_rise = st_r.csn_s[1] & ~st_r.csn_s[2];
   assign csn_fall = ~st_r.csn_s[1] & st_r.csn_s[2];

   // one location per register, unmapped addresses read as zero
   function automatic logic [7:0] rd_mux(input logic [6:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         ADR_OPT_TRIM_H: v = q_opt;
         ADR_OSC_CAL_H: v = ro_in.osc_cal_h;
         ADR_CDR_LIM_H: v = q_cdrh;
         ADR_CDR_LIM_L: v = q_cdrl;
         ADR_SUPPLY_STATUS_SECOND: v = q_sup2;
         ADR_SUPPLY_STATUS_FIRST: v = q_sup1;
         ADR_THERMAL_STATUS: v = q_therm;
         ADR_DEV_COND: v = q_dev;
         ADR_SELECTIVE_WAKE_STATUS: v = ro_in.swk & MSK_SELECTIVE_WAKE_STATUS;
         ADR_ECNT_STAT: v = ro_in.ecnt & MSK_ECNT;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // present content of the addressed byte; a plain signal so the echo check can look back at it
   always_comb begin
      echo_now = rd_mux(st_r.rx[ADDR_BITS-1:0]);
   end

   // ************************************************************
   // serial frame engine
   // ************************************************************
   // sclk idles low; mosi sampled on rise, miso moved on fall, lsb first
   always_comb begin
      st_nxt = st_r;
      st_nxt.sclk_s = {st_r.sclk_s[1:0], pins.sclk};
      st_nxt.csn_s = {st_r.csn_s[1:0], pins.csn};
      st_nxt.mosi_s = {st_r.mosi_s[0], pins.mosi};
      st_nxt.wr_pulse = 1'b0;
      case (st_r.fsm)
         SRA_IDLE: begin
            st_nxt.miso = 1'b0;
            if (csn_fall) begin
               st_nxt.fsm = SRA_SHIFT;
               st_nxt.cnt = 5'h00;
               st_nxt.rx = 16'h0000;
               st_nxt.tx = 8'h00;
            end
         end
         SRA_SHIFT: begin
            if (csn_rise) begin
               st_nxt.fsm = SRA_IDLE;
               // a cut frame may end with a data bit up; drop it with the enable
               st_nxt.miso = 1'b0;
               // only a whole sixteen-bit frame may commit
               if (st_r.cnt == CNT_FULL) begin
                  st_nxt.wr_mode = st_r.rx[MODE_POS];
                  st_nxt.wr_addr = st_r.rx[ADDR_BITS-1:0];
                  st_nxt.wr_data = st_r.rx[CMD_BITS-1:DATA_LSB];
                  st_nxt.wr_pulse = st_r.rx[MODE_POS];
               end
            end else if (sclk_rise) begin
               if (st_r.cnt < CNT_FULL) begin
                  st_nxt.rx[st_r.cnt[3:0]] = st_r.mosi_s[1];
               end
               // saturate so an over-long frame stays invalid
               if (st_r.cnt != CNT_OVER) begin
                  st_nxt.cnt = st_r.cnt + 5'h01;
               end
               // snapshot before any commit, so a write echoes the old byte
               if (st_r.cnt == CNT_ADDR_DONE) begin
                  st_nxt.tx = rd_mux(st_r.rx[ADDR_BITS-1:0]);
               end
            end else if (sclk_fall) begin
               if (st_r.cnt >= 5'h08 && st_r.cnt < CNT_FULL) begin
                  st_nxt.miso = st_r.tx[st_r.cnt[2:0]];
               end else begin
                  st_nxt.miso = 1'b0;
               end
            end
         end
         default: begin
            st_nxt.fsm = SRA_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '{fsm: SRA_IDLE, sclk_s: 3'h0, csn_s: 3'h7, mosi_s: 2'h0,
                   cnt: 5'h00, rx: 16'h0000, tx: 8'h00, miso: 1'b0,
                   wr_pulse: 1'b0, wr_mode: 1'b0, wr_addr: 7'h00, wr_data: 8'h00};
      end else begin
         st_r <= st_nxt;
      end
   end

   // miso driven only inside a frame; enable low means driving
   assign miso_o = st_r.miso;
   assign miso_oe_n = (st_r.fsm == SRA_SHIFT) ? 1'b0 : 1'b1;

   // ************************************************************
   // register bank
   // ************************************************************
   // control bytes: the master owns them, only a soft reset touches them here
   sra_reg_cell #(.POR_VAL(POR_CTRL), .RST_VAL(RST_CTRL), .KEEP_MSK(KEEP_CTRL),
      .BIT_MSK(MSK_OPT_TRIM_H), .CLR_ON_WR(1'b0)) u_opt (
      .core_clk(core_clk), .reset_n(reset_n), .soft_rst(soft_rst), .restart(restart),
      .wr_en(st_r.wr_pulse && st_r.wr_addr == ADR_OPT_TRIM_H),
      .wr_data(st_r.wr_data), .hw_set(8'h00), .q(q_opt)
   );
   sra_reg_cell #(.POR_VAL(POR_CTRL), .RST_VAL(RST_CTRL), .KEEP_MSK(KEEP_CTRL),
      .BIT_MSK(MSK_FULL), .CLR_ON_WR(1'b0)) u_cdrh (
      .core_clk(core_clk), .reset_n(reset_n), .soft_rst(soft_rst), .restart(restart),
      .wr_en(st_r.wr_pulse && st_r.wr_addr == ADR_CDR_LIM_H),
      .wr_data(st_r.wr_data), .hw_set(8'h00), .q(q_cdrh)
   );
   sra_reg_cell #(.POR_VAL(POR_CTRL), .RST_VAL(RST_CTRL), .KEEP_MSK(KEEP_CTRL),
      .BIT_MSK(MSK_FULL), .CLR_ON_WR(1'b0)) u_cdrl (
      .core_clk(core_clk), .reset_n(reset_n), .soft_rst(soft_rst), .restart(restart),
      .wr_en(st_r.wr_pulse && st_r.wr_addr == ADR_CDR_LIM_L),
      .wr_data(st_r.wr_data), .hw_set(8'h00), .q(q_cdrl)
   );
   // status bytes: hardware sets, a write-mode access clears
   sra_reg_cell #(.POR_VAL(POR_STAT), .RST_VAL(RST_STAT), .KEEP_MSK(KEEP_STAT),
      .BIT_MSK(MSK_SUPPLY_STATUS_SECOND), .CLR_ON_WR(1'b1)) u_sup2 (
      .core_clk(core_clk), .reset_n(reset_n), .soft_rst(soft_rst), .restart(restart),
      .wr_en(st_r.wr_pulse && st_r.wr_addr == ADR_SUPPLY_STATUS_SECOND),
      .wr_data(st_r.wr_data), .hw_set(evt.sup2), .q(q_sup2)
   );
   sra_reg_cell #(.POR_VAL(POR_SUPPLY_STATUS_FIRST), .RST_VAL(RST_STAT), .KEEP_MSK(KEEP_STAT),
      .BIT_MSK(MSK_FULL), .CLR_ON_WR(1'b1)) u_sup1 (
      .core_clk(core_clk), .reset_n(reset_n), .soft_rst(soft_rst), .restart(restart),
      .wr_en(st_r.wr_pulse && st_r.wr_addr == ADR_SUPPLY_STATUS_FIRST),
      .wr_data(st_r.wr_data), .hw_set(evt.sup1), .q(q_sup1)
   );
   sra_reg_cell #(.POR_VAL(POR_STAT), .RST_VAL(RST_STAT), .KEEP_MSK(KEEP_STAT),
      .BIT_MSK(MSK_THERM), .CLR_ON_WR(1'b1)) u_therm (
      .core_clk(core_clk), .reset_n(reset_n), .soft_rst(soft_rst), .restart(restart),
      .wr_en(st_r.wr_pulse && st_r.wr_addr == ADR_THERMAL_STATUS),
      .wr_data(st_r.wr_data), .hw_set(evt.therm), .q(q_therm)
   );
   sra_reg_cell #(.POR_VAL(POR_STAT), .RST_VAL(RST_STAT), .KEEP_MSK(KEEP_STAT),
      .BIT_MSK(MSK_DEV_COND), .CLR_ON_WR(1'b1)) u_dev (
      .core_clk(core_clk), .reset_n(reset_n), .soft_rst(soft_rst), .restart(restart),
      .wr_en(st_r.wr_pulse && st_r.wr_addr == ADR_DEV_COND),
      .wr_data(st_r.wr_data), .hw_set(evt.dev), .q(q_dev)
   );
   // read-only bytes are live views; writes to them simply find no cell
   assign ctrl = '{opt_trim_h: q_opt, cdr_lim_h: q_cdrh, cdr_lim_l: q_cdrl};

   // ************************************************************
   // checks
   // ************************************************************
   sequence seq_full_end;
      csn_rise && st_r.fsm == SRA_SHIFT && st_r.cnt == CNT_FULL;
   endsequence
   sequence seq_addr_done;
      st_r.fsm == SRA_SHIFT && !csn_rise && sclk_rise && st_r.cnt == CNT_ADDR_DONE;
   endsequence

   a_write_commit: assert property (@(posedge core_clk) disable iff (!reset_n)
      (seq_full_end and st_r.rx[MODE_POS]) |=> (st_r.wr_pulse && st_r.wr_mode) ##1
      (st_r.wr_addr != ADR_CDR_LIM_H || $past(soft_rst) || $past(restart) || ctrl.cdr_lim_h == st_r.wr_data))
      else $error("write did not land");
   a_read_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
      (seq_full_end and !st_r.rx[MODE_POS]) |=> (!st_r.wr_pulse && !st_r.wr_mode))
      else $error("read produced a write");
   a_frame_len: assert property (@(posedge core_clk) disable iff (!reset_n)
      (csn_rise && st_r.cnt != CNT_FULL) |=> !st_r.wr_pulse)
      else $error("short or long frame committed");
   a_data_order: assert property (@(posedge core_clk) disable iff (!reset_n)
      (seq_full_end and st_r.rx[MODE_POS]) |=>
      (st_r.wr_data == $past(st_r.rx[15:8]) && st_r.wr_addr == $past(st_r.rx[6:0])))
      else $error("data byte misplaced");
   a_old_echo: assert property (@(posedge core_clk) disable iff (!reset_n)
      seq_addr_done |=> (st_r.tx == $past(echo_now)))
      else $error("echo is not the previous content");
   a_rsvd_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
      ((q_opt & ~MSK_OPT_TRIM_H) == 8'h00 && (q_therm & ~MSK_THERM) == 8'h00
       && (q_dev & ~MSK_DEV_COND) == 8'h00))
      else $error("reserved bit reads one");
   a_rc_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
      (st_r.wr_pulse && st_r.wr_addr == ADR_SUPPLY_STATUS_FIRST && !soft_rst && !restart && evt.sup1 == 8'h00)
      |=> q_sup1 == 8'h00)
      else $error("status write did not clear");
   a_soft_por: assert property (@(posedge core_clk) disable iff (!reset_n)
      soft_rst |=> (q_cdrh == POR_CTRL && q_cdrl == POR_CTRL && q_opt == POR_CTRL))
      else $error("soft reset value wrong");
   a_miso_idle: assert property (@(posedge core_clk) disable iff (!reset_n)
      (st_r.fsm == SRA_IDLE) |-> (miso_oe_n && !miso_o))
      else $error("miso driven outside frame");
endmodule // sra_spi_bank
`default_nettype wire

// >>> test/sra_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// serial master model, mode 0, lsb first
// ************************************************************
module sra_spi_master
   import sra_pkg::*;
(
   input wire logic core_clk,
   input wire logic miso,
   input wire logic miso_oe_n,
   output var sra_pins_t pins
);
   localparam int HALF = 16; // 160 ns serial clock at 5 ns core clock
   // link idles with select high and the clock parked low
   initial begin
      pins = '{sclk: 1'b0, csn: 1'b1, mosi: 1'b0};
   end
   // one frame of n bits, rd gathers bits 8..15, ok drops if the first byte echo is not zero
   task automatic frame(input logic [15:0] cmd, input int n, output logic [7:0] rd, output logic ok);
      rd = 8'h00;
      ok = 1'b1;
      @(posedge core_clk);
      pins.csn <= 1'b0;
      pins.mosi <= cmd[0];
      repeat (8) @(posedge core_clk);
      for (int i = 0; i < n; i++) begin
         // miso changed three clocks after the last fall, so it is settled here
         if (i >= 8) begin
            rd[i-8] = miso;
         end else if (miso !== 1'b0 || miso_oe_n !== 1'b0) begin
            ok = 1'b0;
         end
         pins.sclk <= 1'b1;
         repeat (HALF) @(posedge core_clk);
         pins.sclk <= 1'b0;
         pins.mosi <= cmd[(i+1)%16];
         repeat (HALF) @(posedge core_clk);
      end
      repeat (8) @(posedge core_clk);
      pins.csn <= 1'b1;
      pins.mosi <= ~pins.mosi; // released line shows no stale data
      repeat (8) @(posedge core_clk);
   endtask
endmodule // sra_spi_master
`default_nettype wire

// >>> test/sra_spi_bank_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sra_spi_bank_tb_top
   import sra_pkg::*;
;
   // ************************************************************
   // stimulus and design
   // ************************************************************
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic soft_rst = 1'b0;
   logic restart = 1'b0;
   sra_pins_t pins;
   logic miso_o;
   logic miso_oe_n;
   sra_evt_t evt = '0;
   sra_ro_t ro_in = '0;
   sra_ctrl_t ctrl;
   int n_mismatch = 0;
   int compares = 0;
   int cycles = 0;
   logic [7:0] exp_r [0:127];
   localparam logic [6:0] ADRS [0:9] = '{ADR_OPT_TRIM_H, ADR_OSC_CAL_H, ADR_CDR_LIM_H, ADR_CDR_LIM_L,
      ADR_SUPPLY_STATUS_SECOND, ADR_SUPPLY_STATUS_FIRST, ADR_THERMAL_STATUS, ADR_DEV_COND, ADR_SELECTIVE_WAKE_STATUS, ADR_ECNT_STAT};
   always #2.5 core_clk = ~core_clk;
   sra_spi_bank i_dut (.core_clk(core_clk), .reset_n(reset_n), .pins(pins), .miso_o(miso_o),
      .miso_oe_n(miso_oe_n), .soft_rst(soft_rst), .restart(restart), .evt(evt), .ro_in(ro_in), .ctrl(ctrl));
   sra_spi_master i_master (.core_clk(core_clk), .miso(miso_o), .miso_oe_n(miso_oe_n), .pins(pins));
   // ************************************************************
   // expectation helpers
   // ************************************************************
   function automatic logic [7:0] mask_of(logic [6:0] a);
      case (a)
         ADR_OPT_TRIM_H: mask_of = MSK_OPT_TRIM_H;
         ADR_OSC_CAL_H, ADR_CDR_LIM_H, ADR_CDR_LIM_L, ADR_SUPPLY_STATUS_FIRST: mask_of = MSK_FULL;
         ADR_SUPPLY_STATUS_SECOND: mask_of = MSK_SUPPLY_STATUS_SECOND;
         ADR_THERMAL_STATUS: mask_of = MSK_THERM;
         ADR_DEV_COND: mask_of = MSK_DEV_COND;
         ADR_SELECTIVE_WAKE_STATUS: mask_of = MSK_SELECTIVE_WAKE_STATUS;
         ADR_ECNT_STAT: mask_of = MSK_ECNT;
         default: mask_of = 8'h00;
      endcase
   endfunction
   function automatic logic is_ctrl(logic [6:0] a);
      is_ctrl = a inside {ADR_OPT_TRIM_H, ADR_CDR_LIM_H, ADR_CDR_LIM_L};
   endfunction
   function automatic logic is_rc(logic [6:0] a);
      is_rc = a inside {ADR_SUPPLY_STATUS_SECOND, ADR_SUPPLY_STATUS_FIRST, ADR_THERMAL_STATUS, ADR_DEV_COND};
   endfunction
   // power-on view: controls and flags clear except the power-on flag
   task por_exp();
      for (int k = 0; k < 10; k++) begin
         if (is_ctrl(ADRS[k])) begin
            exp_r[ADRS[k]] = POR_CTRL;
         end
         if (is_rc(ADRS[k])) begin
            exp_r[ADRS[k]] = POR_STAT;
         end
      end
      exp_r[ADR_SUPPLY_STATUS_FIRST] = POR_SUPPLY_STATUS_FIRST;
   endtask
   // ************************************************************
   // checking tasks
   // ************************************************************
   task check(input string what, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", what, e, g);
         n_mismatch++;
      end
   endtask
   task ctrl_chk();
      check("ctrl.opt_trim_h", exp_r[ADR_OPT_TRIM_H], ctrl.opt_trim_h);
      check("ctrl.cdr_lim_h", exp_r[ADR_CDR_LIM_H], ctrl.cdr_lim_h);
      check("ctrl.cdr_lim_l", exp_r[ADR_CDR_LIM_L], ctrl.cdr_lim_l);
   endtask
   // a frame of n bits; the data byte out is always the content before this frame
   task automatic access(input logic [6:0] a, input logic wr, input logic [7:0] d, input int n = 16);
      logic [7:0] rd;
      logic ok;
      logic [7:0] old;
      old = exp_r[a] & mask_of(a);
      i_master.frame({d, wr, a}, n, rd, ok);
      check("first byte echo", 8'h01, {7'h00, ok});
      if (n == 16) begin
         check("serial read data", old, rd);
         if (wr && is_ctrl(a)) exp_r[a] = d;
         if (wr && is_rc(a)) exp_r[a] = 8'h00;
      end
   endtask
   task read_all();
      for (int k = 0; k < 10; k++) access(ADRS[k], 1'b0, 8'h00);
      access(7'h00, 1'b0, 8'h00);
   endtask
   // one-cycle set pulses on every status register at once
   task pulse_evt();
      sra_evt_t e;
      e = $urandom;
      @(posedge core_clk);
      evt <= e;
      @(posedge core_clk);
      evt <= '0;
      exp_r[ADR_SUPPLY_STATUS_SECOND] |= e.sup2;
      exp_r[ADR_SUPPLY_STATUS_FIRST] |= e.sup1;
      exp_r[ADR_THERMAL_STATUS] |= e.therm;
      exp_r[ADR_DEV_COND] |= e.dev;
   endtask
   task stop_test();
      if (n_mismatch == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // hang guard, about 80 percent above the expected run length
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 95000) begin
         n_mismatch++;
         stop_test();
      end
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      logic [31:0] u;
      logic [6:0] a;
      void'($urandom(73));
      for (int k = 0; k < 128; k++) exp_r[k] = 8'h00;
      por_exp();
      repeat (20) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      ctrl_chk();
      u = $urandom;
      ro_in <= u[23:0];
      {exp_r[ADR_OSC_CAL_H], exp_r[ADR_SELECTIVE_WAKE_STATUS], exp_r[ADR_ECNT_STAT]} = u[23:0];
      read_all();
      // all-ones to the three controls, then random values to random mapped registers, reserved bits written as zero
      for (int k = 0; k < 12; k++) begin
         a = (k < 3) ? ADRS[k+(k>0)] : ADRS[$urandom_range(9, 0)];
         u = (k < 3) ? 32'hFF : $urandom;
         access(a, 1'b1, u[7:0] & mask_of(a));
         access(a, 1'b0, 8'h00);
         ctrl_chk();
      end
      // writes to read-only and unmapped places change nothing
      access(ADR_OSC_CAL_H, 1'b1, 8'hA5);
      access(ADR_ECNT_STAT, 1'b1, 8'h3F);
      access(7'h7F, 1'b1, 8'hFF);
      // hardware sets, reads keep flags, writes clear them
      pulse_evt();
      read_all();
      read_all();
      for (int k = 4; k < 8; k++) access(ADRS[k], 1'b1, 8'h00);
      read_all();
      ctrl_chk();
      // frames of wrong length are thrown away
      access(ADR_CDR_LIM_H, 1'b1, ~exp_r[ADR_CDR_LIM_H], 12);
      access(ADR_CDR_LIM_L, 1'b1, ~exp_r[ADR_CDR_LIM_L], 15);
      ctrl_chk();
      // restart keeps every bit
      pulse_evt();
      @(posedge core_clk);
      restart <= 1'b1;
      @(posedge core_clk);
      restart <= 1'b0;
      repeat (2) @(posedge core_clk);
      ctrl_chk();
      read_all();
      // soft reset brings back power-on values
      @(posedge core_clk);
      soft_rst <= 1'b1;
      @(posedge core_clk);
      soft_rst <= 1'b0;
      por_exp();
      repeat (2) @(posedge core_clk);
      ctrl_chk();
      read_all();
      stop_test();
   end
endmodule // sra_spi_bank_tb_top
`default_nettype wire
